// *** sos_pkg.sv ***
// Package with shared constants and types for the supply output sequencer
package sos_pkg;
  // Status word bit positions
  localparam int OP_PRIMED   = 0;
  localparam int OP_SOFT     = 1;
  localparam int OP_SECURED  = 2;
  localparam int OP_FRONT    = 3;
  localparam int OP_REAR     = 4;
  localparam int OP_AWAIT    = 5;
  localparam int OP_STANDBY  = 6;
  localparam int OP_POWER    = 7;
  localparam int OP_CV       = 8;
  localparam int OP_SENSE    = 9;
  localparam int OP_CC       = 10;
  localparam int OP_STBYFLT  = 11;
  localparam int FT_VOLT     = 0;
  localparam int FT_CURR     = 1;
  localparam int FT_PHASE    = 2;
  localparam int FT_PROG     = 3;
  localparam int FT_THERM    = 4;
  localparam int FT_LINK     = 5;
  localparam int FT_GENERAL  = 7;
  localparam int FT_SAFETY   = 8;
  localparam int FT_HOST     = 9;
  // Sequence memory and dwell encoding
  localparam int         MEM_DEPTH    = 100;
  localparam logic [6:0] LAST_ENTRY   = 7'h63;
  localparam logic [6:0] FIRST_ENTRY  = 7'h00;
  localparam logic [13:0] DWELL_STOP  = 14'h0000;
  localparam logic [13:0] DWELL_ZERO  = 14'h270E;
  localparam logic [13:0] DWELL_HOLD  = 14'h270F;
  localparam logic [13:0] DWELL_SEC   = 14'h2710;
  // Dwell tick: 10 ms at 100 MHz
  localparam int CLK_MHZ   = 100;
  localparam int TICK_MS   = 10;
  localparam int TICK_CYC  = TICK_MS * 1000 * CLK_MHZ;
  localparam int SEC_TICKS = 100;
  // Host command codes
  typedef enum logic [3:0] {
    SOS_CMD_NONE   = 4'h0,
    SOS_CMD_RUN    = 4'h1,
    SOS_CMD_HALT   = 4'h2,
    SOS_CMD_CLEAR  = 4'h3,
    SOS_CMD_CANCEL = 4'h4,
    SOS_CMD_FIRE   = 4'h5,
    SOS_CMD_ENABLE = 4'h6,
    SOS_CMD_SEQ    = 4'h7,
    SOS_CMD_CONT   = 4'h8,
    SOS_CMD_RESET  = 4'h9,
    SOS_CMD_RECALL = 4'hA,
    SOS_CMD_START  = 4'hB,
    SOS_CMD_IMMV   = 4'hC,
    SOS_CMD_IMMI   = 4'hD,
    SOS_CMD_PENDV  = 4'hE,
    SOS_CMD_PENDI  = 4'hF
  } sos_cmd_t;
  // One sequence memory entry
  typedef struct packed {
    logic [15:0] volt_set;
    logic [15:0] curr_set;
    logic [15:0] volt_trip;
    logic [15:0] curr_trip;
    logic [13:0] dwell;
  } sos_entry_t;
  localparam int ENTRY_W = $bits(sos_entry_t);
  // Host command with argument
  typedef struct packed {
    sos_cmd_t    code;
    logic [15:0] arg;
  } sos_req_t;
  // Raw fault inputs from the power stage
  typedef struct packed {
    logic safety;
    logic prog;
    logic phase;
    logic therm;
    logic volt;
    logic curr;
    logic link;
  } sos_fault_t;
  // Sequencer states
  typedef enum logic [1:0] {
    SOS_IDLE = 2'b00,
    SOS_RUN  = 2'b01,
    SOS_AUTO = 2'b11
  } sos_state_t;
endpackage : sos_pkg

// *** sos_seq_mem.sv ***
// Setpoint memory for auto-sequencing, registered read data
module sos_seq_mem #(
  parameter int DEPTH = sos_pkg::MEM_DEPTH,
  parameter int AW    = 7
) (
  // Clock
  input  wire logic                  mclk_in,
  // Write port
  input  wire logic                  wr_en_in,
  input  wire logic [AW-1:0]         wr_addr_in,
  input  wire sos_pkg::sos_entry_t   wr_data_in,
  // Read port
  input  wire logic [AW-1:0]         rd_addr_in,
  output sos_pkg::sos_entry_t        rd_data_out
);
  sos_pkg::sos_entry_t mem [DEPTH];
  sos_pkg::sos_entry_t rd_reg;

  // Write and registered read
  always_ff @(posedge mclk_in) begin
    if (wr_en_in && (int'(wr_addr_in) < DEPTH)) begin
      mem[wr_addr_in] <= wr_data_in;
    end
    rd_reg <= mem[rd_addr_in];
  end

  assign rd_data_out = rd_reg;
endmodule : sos_seq_mem

// *** sos_sequencer.sv ***
// Output control, fault latches, trigger and auto-sequence core
module sos_sequencer #(
  parameter int TICK_CYCLES = sos_pkg::TICK_CYC
) (
  // Clock and reset
  input  wire logic                 mclk_in,
  input  wire logic                 rst_in,
  // Host commands
  input  wire sos_pkg::sos_req_t    req_in,
  input  wire logic                 req_valid_in,
  // Sequence memory programming
  input  wire logic                 mem_wr_in,
  input  wire logic [6:0]           mem_addr_in,
  input  wire sos_pkg::sos_entry_t  mem_data_in,
  // Power stage status pins
  input  wire sos_pkg::sos_fault_t  fault_pin_in,
  input  wire logic [4:0]           stage_pin_in,
  input  wire logic [15:0]          volt_meas_in,
  input  wire logic [15:0]          curr_meas_in,
  // Status words and indications
  output logic [15:0]               run_state_flags_out,
  output logic [15:0]               fault_state_flags_out,
  output logic                      output_on_out,
  output logic                      seq_enable_out,
  output logic                      continuous_reenable_out,
  output logic                      seq_lamp_out,
  // Power stage control
  output logic                      contactor_out,
  output logic [15:0]               volt_set_out,
  output logic [15:0]               curr_set_out,
  output logic [15:0]               volt_trip_out,
  output logic [15:0]               curr_trip_out
);
  // Pin synchronisers
  sos_pkg::sos_fault_t flt_s1_reg, flt_s2_reg;
  logic [4:0]  stg_s1_reg, stg_s2_reg;
  logic [15:0] vm_s1_reg, vm_s2_reg, im_s1_reg, im_s2_reg;
  always_ff @(posedge mclk_in) begin
    flt_s1_reg <= fault_pin_in;
    flt_s2_reg <= flt_s1_reg;
    stg_s1_reg <= stage_pin_in;
    stg_s2_reg <= stg_s1_reg;
    vm_s1_reg  <= volt_meas_in;
    vm_s2_reg  <= vm_s1_reg;
    im_s1_reg  <= curr_meas_in;
    im_s2_reg  <= im_s1_reg;
  end

  // Control state
  sos_pkg::sos_state_t state_reg, state_next;
  logic [6:0]  entry_reg, entry_next;
  logic        seq_en_reg, seq_en_next;
  logic        cont_reg, cont_next;
  logic        armed_reg, armed_next;
  logic        pend_v_ok_reg, pend_v_ok_next, pend_i_ok_reg, pend_i_ok_next;
  logic [15:0] imm_v_reg, imm_v_next, imm_i_reg, imm_i_next;
  logic [15:0] pend_v_reg, pend_v_next, pend_i_reg, pend_i_next;
  logic [15:0] vset_reg, vset_next, iset_reg, iset_next;
  logic [15:0] vtrip_reg, vtrip_next, itrip_reg, itrip_next;
  logic [6:0]  latch_reg, latch_next;
  logic        trip_v_reg, trip_v_next, trip_i_reg, trip_i_next;
  logic        opclr_reg, opclr_next;
  logic        load_reg, load_next, apply_reg;
  logic        zero_next_reg, zero_next_next;
  logic [13:0] dwell_reg, dwell_next;
  logic [6:0]  sub_reg, sub_next;
  logic [31:0] tick_cnt_reg, tick_cnt_next;
  logic [23:0] blink_reg, blink_next;
  sos_pkg::sos_entry_t rd_entry;
  sos_pkg::sos_fault_t raw;
  logic        is_cmd;
  logic        any_fault;
  logic        tick;
  logic        step_done;

  // Sequence memory
  sos_seq_mem #(.DEPTH(sos_pkg::MEM_DEPTH), .AW(7)) u_mem (
    .mclk_in     (mclk_in),
    .wr_en_in    (mem_wr_in),
    .wr_addr_in  (mem_addr_in),
    .wr_data_in  (mem_data_in),
    .rd_addr_in  (entry_reg),
    .rd_data_out (rd_entry)
  );

  // Fault sources, including comparator trips
  always_comb begin
    raw      = flt_s2_reg;
    raw.volt = flt_s2_reg.volt | (contactor_out && (vm_s2_reg > vtrip_reg));
    raw.curr = flt_s2_reg.curr | (contactor_out && (im_s2_reg > itrip_reg));
    is_cmd   = req_valid_in;
    tick     = (tick_cnt_reg == 32'(TICK_CYCLES - 1));
    step_done = tick && (dwell_reg != sos_pkg::DWELL_HOLD) &&
                ((dwell_reg < sos_pkg::DWELL_ZERO) ? (dwell_reg <= 14'h0001)
                                                    : (sub_reg == 7'(sos_pkg::SEC_TICKS - 1)));
  end

  // Next-state logic for the whole core
  always_comb begin
    state_next     = state_reg;
    entry_next     = entry_reg;
    seq_en_next    = seq_en_reg;
    cont_next      = cont_reg;
    armed_next     = armed_reg;
    pend_v_ok_next = pend_v_ok_reg;
    pend_i_ok_next = pend_i_ok_reg;
    imm_v_next     = imm_v_reg;
    imm_i_next     = imm_i_reg;
    pend_v_next    = pend_v_reg;
    pend_i_next    = pend_i_reg;
    vset_next      = vset_reg;
    iset_next      = iset_reg;
    vtrip_next     = vtrip_reg;
    itrip_next     = itrip_reg;
    opclr_next     = opclr_reg;
    load_next      = 1'b0;
    zero_next_next = zero_next_reg;
    dwell_next     = dwell_reg;
    sub_next       = sub_reg;
    trip_v_next    = trip_v_reg;
    trip_i_next    = trip_i_reg;
    tick_cnt_next  = tick ? 32'h0000_0000 : tick_cnt_reg + 32'h0000_0001;
    blink_next     = blink_reg + 24'h00_0001;
    // latches set on any fault, set wins over clear
    latch_next     = latch_reg;
    if (is_cmd && req_in.code == sos_pkg::SOS_CMD_CLEAR) begin
      latch_next = 7'h00;
    end
    latch_next = latch_next | raw;
    any_fault  = |latch_next;
    // Dwell countdown
    if (state_reg == sos_pkg::SOS_AUTO && tick) begin
      if (dwell_reg >= sos_pkg::DWELL_ZERO) begin
        sub_next = (sub_reg == 7'(sos_pkg::SEC_TICKS - 1)) ? 7'h00 : sub_reg + 7'h01;
      end else if (dwell_reg != 14'h0000) begin
        dwell_next = dwell_reg - 14'h0001;
      end
    end
    if (is_cmd) begin
      unique case (req_in.code)
        sos_pkg::SOS_CMD_RUN: begin
          // run during a step advances early
          if (state_reg == sos_pkg::SOS_AUTO) begin
            entry_next = (entry_reg == sos_pkg::LAST_ENTRY) ? sos_pkg::FIRST_ENTRY : entry_reg + 7'h01;
            load_next  = 1'b1;
          end else if (state_reg == sos_pkg::SOS_IDLE && !any_fault) begin
            opclr_next = 1'b0;
            if (seq_en_reg) begin
              state_next = sos_pkg::SOS_AUTO;
              load_next  = 1'b1;
            end else begin
              state_next = sos_pkg::SOS_RUN;
            end
          end
        end
        sos_pkg::SOS_CMD_HALT:   state_next = sos_pkg::SOS_IDLE;
        sos_pkg::SOS_CMD_CLEAR: begin
          trip_v_next = 1'b0;
          trip_i_next = 1'b0;
        end
        sos_pkg::SOS_CMD_CANCEL, sos_pkg::SOS_CMD_RESET, sos_pkg::SOS_CMD_RECALL: begin
          pend_v_next    = imm_v_reg;
          pend_i_next    = imm_i_reg;
          pend_v_ok_next = 1'b0;
          pend_i_ok_next = 1'b0;
          armed_next     = cont_reg;
        end
        sos_pkg::SOS_CMD_FIRE: begin
          if (armed_reg) begin
            vset_next  = pend_v_reg;
            iset_next  = pend_i_reg;
            imm_v_next = pend_v_reg;
            imm_i_next = pend_i_reg;
            pend_v_ok_next = 1'b0;
            pend_i_ok_next = 1'b0;
            opclr_next = 1'b1;
            armed_next = cont_reg;
          end
        end
        sos_pkg::SOS_CMD_ENABLE: armed_next = 1'b1;
        sos_pkg::SOS_CMD_SEQ:    seq_en_next = req_in.arg[0];
        sos_pkg::SOS_CMD_CONT:   cont_next = req_in.arg[0];
        sos_pkg::SOS_CMD_START: begin
          if (state_reg == sos_pkg::SOS_IDLE) begin
            entry_next = (req_in.arg[6:0] > sos_pkg::LAST_ENTRY) ? sos_pkg::FIRST_ENTRY : req_in.arg[6:0];
          end
        end
        sos_pkg::SOS_CMD_IMMV: begin
          imm_v_next = req_in.arg;
          vset_next  = req_in.arg;
          if (!pend_v_ok_reg) pend_v_next = req_in.arg;
        end
        sos_pkg::SOS_CMD_IMMI: begin
          imm_i_next = req_in.arg;
          iset_next  = req_in.arg;
          if (!pend_i_ok_reg) pend_i_next = req_in.arg;
        end
        sos_pkg::SOS_CMD_PENDV: begin
          if (armed_reg) begin
            pend_v_next    = req_in.arg;
            pend_v_ok_next = 1'b1;
          end
        end
        sos_pkg::SOS_CMD_PENDI: begin
          if (armed_reg) begin
            pend_i_next    = req_in.arg;
            pend_i_ok_next = 1'b1;
          end
        end
        default: ;
      endcase
    end
    if (state_reg == sos_pkg::SOS_AUTO && step_done && !load_next && !load_reg && !apply_reg) begin
      entry_next = (entry_reg == sos_pkg::LAST_ENTRY) ? sos_pkg::FIRST_ENTRY : entry_reg + 7'h01;
      load_next  = 1'b1;
    end
    // entry loads all five fields
    // Read data stands one cycle after the address moves
    if (apply_reg && state_reg != sos_pkg::SOS_IDLE) begin
      vset_next  = zero_next_reg ? 16'h0000 : rd_entry.volt_set;
      iset_next  = zero_next_reg ? 16'h0000 : rd_entry.curr_set;
      vtrip_next = rd_entry.volt_trip;
      itrip_next = rd_entry.curr_trip;
      dwell_next = rd_entry.dwell;
      sub_next   = 7'h00;
      zero_next_next = (rd_entry.dwell == sos_pkg::DWELL_ZERO);
      if (rd_entry.dwell == sos_pkg::DWELL_STOP) state_next = sos_pkg::SOS_IDLE;
    end
    if (raw.volt) trip_v_next = 1'b1;
    if (raw.curr) trip_i_next = 1'b1;
    if (any_fault) state_next = sos_pkg::SOS_IDLE;
    if (state_next == sos_pkg::SOS_IDLE) begin
      load_next      = 1'b0;
      zero_next_next = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_reg     <= sos_pkg::SOS_IDLE;
      entry_reg     <= sos_pkg::FIRST_ENTRY;
      seq_en_reg    <= 1'b0;
      cont_reg      <= 1'b0;
      armed_reg     <= 1'b0;
      pend_v_ok_reg <= 1'b0;
      pend_i_ok_reg <= 1'b0;
      imm_v_reg     <= 16'h0000;
      imm_i_reg     <= 16'h0000;
      pend_v_reg    <= 16'h0000;
      pend_i_reg    <= 16'h0000;
      vset_reg      <= 16'h0000;
      iset_reg      <= 16'h0000;
      vtrip_reg     <= 16'hFFFF;
      itrip_reg     <= 16'hFFFF;
      latch_reg     <= 7'h00;
      trip_v_reg    <= 1'b0;
      trip_i_reg    <= 1'b0;
      opclr_reg     <= 1'b0;
      load_reg      <= 1'b0;
      apply_reg     <= 1'b0;
      zero_next_reg <= 1'b0;
      dwell_reg     <= 14'h0000;
      sub_reg       <= 7'h00;
      tick_cnt_reg  <= 32'h0000_0000;
      blink_reg     <= 24'h00_0000;
    end else begin
      state_reg     <= state_next;
      entry_reg     <= entry_next;
      seq_en_reg    <= seq_en_next;
      cont_reg      <= cont_next;
      armed_reg     <= armed_next;
      pend_v_ok_reg <= pend_v_ok_next;
      pend_i_ok_reg <= pend_i_ok_next;
      imm_v_reg     <= imm_v_next;
      imm_i_reg     <= imm_i_next;
      pend_v_reg    <= pend_v_next;
      pend_i_reg    <= pend_i_next;
      vset_reg      <= vset_next;
      iset_reg      <= iset_next;
      vtrip_reg     <= vtrip_next;
      itrip_reg     <= itrip_next;
      latch_reg     <= latch_next;
      trip_v_reg    <= trip_v_next;
      trip_i_reg    <= trip_i_next;
      opclr_reg     <= opclr_next;
      load_reg      <= load_next;
      apply_reg     <= load_reg;
      zero_next_reg <= zero_next_next;
      dwell_reg     <= dwell_next;
      sub_reg       <= sub_next;
      tick_cnt_reg  <= tick_cnt_next;
      blink_reg     <= blink_next;
    end
  end

  // Status words, unused bits zero
  always_comb begin
    run_state_flags_out   = 16'h0000;
    fault_state_flags_out = 16'h0000;
    // fire clears the operation word, except the awaiting bit, until next run
    if (!opclr_reg) begin
      run_state_flags_out[sos_pkg::OP_PRIMED]  = seq_en_reg;
      run_state_flags_out[sos_pkg::OP_SOFT]    = stg_s2_reg[0];
      run_state_flags_out[sos_pkg::OP_SECURED] = stg_s2_reg[1];
      run_state_flags_out[sos_pkg::OP_FRONT]   = stg_s2_reg[2];
      run_state_flags_out[sos_pkg::OP_REAR]    = stg_s2_reg[3];
      run_state_flags_out[sos_pkg::OP_STANDBY] = (state_reg == sos_pkg::SOS_IDLE);
      run_state_flags_out[sos_pkg::OP_POWER]   = (state_reg != sos_pkg::SOS_IDLE);
      run_state_flags_out[sos_pkg::OP_CV]      = (state_reg != sos_pkg::SOS_IDLE) && !stg_s2_reg[4];
      run_state_flags_out[sos_pkg::OP_SENSE]   = stg_s2_reg[2] & stg_s2_reg[3];
      run_state_flags_out[sos_pkg::OP_CC]      = (state_reg != sos_pkg::SOS_IDLE) && stg_s2_reg[4];
      run_state_flags_out[sos_pkg::OP_STBYFLT] = (state_reg == sos_pkg::SOS_IDLE) || (|latch_reg);
    end
    run_state_flags_out[sos_pkg::OP_AWAIT] = armed_reg;
    fault_state_flags_out[sos_pkg::FT_VOLT]    = latch_reg[2] | trip_v_reg;
    fault_state_flags_out[sos_pkg::FT_CURR]    = latch_reg[1] | trip_i_reg;
    fault_state_flags_out[sos_pkg::FT_PHASE]   = latch_reg[4];
    fault_state_flags_out[sos_pkg::FT_PROG]    = latch_reg[5];
    fault_state_flags_out[sos_pkg::FT_THERM]   = latch_reg[3];
    fault_state_flags_out[sos_pkg::FT_LINK]    = latch_reg[0];
    fault_state_flags_out[sos_pkg::FT_GENERAL] = |latch_reg;
    fault_state_flags_out[sos_pkg::FT_SAFETY]  = latch_reg[6];
    fault_state_flags_out[sos_pkg::FT_HOST]    = 1'b1;
  end

  // Control outputs
  // output state
  assign output_on_out           = (state_reg != sos_pkg::SOS_IDLE);
  assign contactor_out           = (state_reg != sos_pkg::SOS_IDLE);
  assign seq_enable_out          = seq_en_reg;
  assign continuous_reenable_out = cont_reg;
  // steady when enabled, blinking while auto-sequencing
  assign seq_lamp_out  = seq_en_reg && ((state_reg != sos_pkg::SOS_AUTO) || blink_reg[23]);
  assign volt_set_out  = vset_reg;
  assign curr_set_out  = iset_reg;
  assign volt_trip_out = vtrip_reg;
  assign curr_trip_out = itrip_reg;
endmodule : sos_sequencer

// *** sos_sequencer_checker.sv ***
// Port checker for the sequencer core
module sos_chk (
  // Clock and reset
  input wire logic                mclk_in,
  input wire logic                rst_in,
  // Observed ports
  input wire sos_pkg::sos_req_t   req_in,
  input wire logic                req_valid_in,
  input wire sos_pkg::sos_fault_t fault_pin_in,
  input wire logic [15:0]         run_state_flags_out,
  input wire logic [15:0]         fault_state_flags_out,
  input wire logic                output_on_out,
  input wire logic                contactor_out,
  input wire logic                continuous_reenable_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Decoded commands and fault presence
  wire logic is_run  = req_valid_in && (req_in.code == sos_pkg::SOS_CMD_RUN);
  wire logic is_halt = req_valid_in && (req_in.code == sos_pkg::SOS_CMD_HALT);
  wire logic is_cont = req_valid_in && (req_in.code == sos_pkg::SOS_CMD_CONT);
  wire logic is_canc = req_valid_in && (req_in.code == sos_pkg::SOS_CMD_CANCEL);
  wire logic is_fire = req_valid_in && (req_in.code == sos_pkg::SOS_CMD_FIRE);
  wire logic any_flt = (fault_pin_in != '0);
  property p_run_unused; run_state_flags_out[15:12] == 4'h0; endproperty
  a_run_unused: assert property (p_run_unused) else $error("run word unused bits set");
  property p_flt_unused; (fault_state_flags_out & 16'hFC40) == 16'h0000; endproperty
  a_flt_unused: assert property (p_flt_unused) else $error("fault word unused bits set");
  property p_host; fault_state_flags_out[sos_pkg::FT_HOST]; endproperty
  a_host: assert property (p_host) else $error("host control bit low");
  property p_out_state; $rose(output_on_out) |-> $past(is_run) && contactor_out; endproperty
  a_out_state: assert property (p_out_state) else $error("output energized without run");
  property p_halt; is_halt |=> !contactor_out; endproperty
  a_halt: assert property (p_halt) else $error("halt left contactor closed");
  property p_refuse; any_flt [*4] ##0 is_run |=> !contactor_out; endproperty
  a_refuse: assert property (p_refuse) else $error("run accepted during fault");
  property p_cont; is_cont |=> continuous_reenable_out == $past(req_in.arg[0]); endproperty
  a_cont: assert property (p_cont) else $error("continuous setting not stored");
  property p_cancel; is_canc |=> run_state_flags_out[sos_pkg::OP_AWAIT] == $past(continuous_reenable_out); endproperty
  a_cancel: assert property (p_cancel) else $error("awaiting flag wrong after cancel");
  property p_alarm; any_flt [*5] |-> ##[0:3] !contactor_out; endproperty
  a_alarm: assert property (p_alarm) else $error("fault did not force idle");
  // Main scenarios reached
  c_run: cover property (is_run ##1 contactor_out);
  c_fire: cover property (is_fire);
  c_canc: cover property (is_canc ##1 run_state_flags_out[sos_pkg::OP_AWAIT]);
endmodule : sos_chk

// *** sos_stage_model.sv ***
// Power stage model: echoes setpoints and injects faults
module sos_stage_model (
  // Control from the core, fault forcing from the bench
  input  wire logic                contactor_in,
  input  wire logic [15:0]         volt_set_in,
  input  wire logic [15:0]         curr_set_in,
  input  wire sos_pkg::sos_fault_t fault_force_in,
  // Status back to the core
  output sos_pkg::sos_fault_t      fault_pin_out,
  output logic [4:0]               stage_pin_out,
  output logic [15:0]              volt_meas_out,
  output logic [15:0]              curr_meas_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // Output only follows setpoints while energized
  assign volt_meas_out = contactor_in ? volt_set_in : 16'h0000;
  assign curr_meas_out = contactor_in ? curr_set_in : 16'h0000;
  assign fault_pin_out = fault_force_in;
  assign stage_pin_out = {4'h4, contactor_in};
endmodule : sos_stage_model

// *** test_supply_output_sequencer.sv ***
// Self-checking bench for the supply output sequencer
module test_supply_output_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  logic                mclk_in = 1'b0;
  logic                rst_in  = 1'b1;
  sos_pkg::sos_req_t   req_in  = '0;
  logic                req_valid_in = 1'b0;
  logic                mem_wr_in = 1'b0;
  logic [6:0]          mem_addr_in = 7'h00;
  sos_pkg::sos_entry_t mem_data_in = '0;
  sos_pkg::sos_fault_t fault_force = '0;
  sos_pkg::sos_fault_t fault_pin;
  logic [4:0]          stage_pin;
  logic [15:0]         vmeas, imeas, run_f, flt_f, vset, iset, vtrip, itrip;
  logic                out_on, seq_en, cont_en, lamp, cont;
  int                  err_count = 0;
  int                  tests_run = 0;
  // Clock at 100 MHz
  always #5 mclk_in = ~mclk_in;
  sos_sequencer #(.TICK_CYCLES(10)) i_dut (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req_in),
    .req_valid_in(req_valid_in), .mem_wr_in(mem_wr_in), .mem_addr_in(mem_addr_in),
    .mem_data_in(mem_data_in), .fault_pin_in(fault_pin), .stage_pin_in(stage_pin),
    .volt_meas_in(vmeas), .curr_meas_in(imeas), .run_state_flags_out(run_f),
    .fault_state_flags_out(flt_f), .output_on_out(out_on), .seq_enable_out(seq_en),
    .continuous_reenable_out(cont_en), .seq_lamp_out(lamp), .contactor_out(cont),
    .volt_set_out(vset), .curr_set_out(iset), .volt_trip_out(vtrip), .curr_trip_out(itrip));
  sos_stage_model i_stage (.contactor_in(cont), .volt_set_in(vset), .curr_set_in(iset),
    .fault_force_in(fault_force), .fault_pin_out(fault_pin), .stage_pin_out(stage_pin),
    .volt_meas_out(vmeas), .curr_meas_out(imeas));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // One command pulse, result settled on return
  task automatic cmd(input sos_pkg::sos_cmd_t c, input logic [15:0] a);
    @(negedge mclk_in);
    req_in.code = c;
    req_in.arg = a;
    req_valid_in = 1'b1;
    @(negedge mclk_in);
    req_valid_in = 1'b0;
    @(negedge mclk_in);
  endtask : cmd
  // Program one sequence entry
  task automatic wr_mem(input logic [6:0] ad, input logic [15:0] v, input logic [13:0] dw);
    @(negedge mclk_in);
    mem_wr_in = 1'b1;
    mem_addr_in = ad;
    mem_data_in = '{v, 16'h0001, 16'hFFFF, 16'hFFFF, dw};
    @(negedge mclk_in);
    mem_wr_in = 1'b0;
  endtask : wr_mem
  // Bounded wait on setpoint (sel 0) or contactor (sel 1)
  task automatic wait_for(input int sel, input logic [15:0] exp);
    int n;
    n = 0;
    while (((sel == 0) ? vset : {15'h0000, cont}) !== exp && n < 2000) begin
      @(negedge mclk_in);
      n++;
    end
    check((sel == 0) ? vset : {15'h0000, cont}, exp);
    if (n >= 2000) report_and_stop();
  endtask : wait_for
  // Counts, verdict and end of run
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  // Main sequence
  initial begin
    repeat (10) @(negedge mclk_in);
    rst_in = 1'b0;
    @(negedge mclk_in);
    check(run_f & 16'hF000, 16'h0000);
    check(flt_f & 16'hFC40, 16'h0000);
    check({15'h0000, run_f[sos_pkg::OP_AWAIT]}, 16'h0000);
    check({15'h0000, out_on}, 16'h0000);
    $display("Test reset state done");
    for (int b = 0; b < 2; b++) begin
      cmd(sos_pkg::SOS_CMD_CONT, 16'(b));
      check({15'h0000, cont_en}, 16'(b));
    end
    cmd(sos_pkg::SOS_CMD_CONT, 16'h0000);
    cmd(sos_pkg::SOS_CMD_IMMV, 16'h0111);
    cmd(sos_pkg::SOS_CMD_RUN, 16'h0000);
    check({14'h0000, out_on, cont}, 16'h0003);
    check(vset, 16'h0111);
    repeat (2) @(negedge mclk_in);
    check(run_f, 16'h0192);
    check(flt_f, 16'h0200);
    cmd(sos_pkg::SOS_CMD_HALT, 16'h0000);
    check({14'h0000, out_on, cont}, 16'h0000);
    $display("Test normal run done");
    cmd(sos_pkg::SOS_CMD_PENDV, 16'h0999);
    cmd(sos_pkg::SOS_CMD_FIRE, 16'h0000);
    check(vset, 16'h0111);
    cmd(sos_pkg::SOS_CMD_ENABLE, 16'h0000);
    check({15'h0000, run_f[sos_pkg::OP_AWAIT]}, 16'h0001);
    cmd(sos_pkg::SOS_CMD_PENDV, 16'h0222);
    cmd(sos_pkg::SOS_CMD_PENDI, 16'h0020);
    cmd(sos_pkg::SOS_CMD_IMMV, 16'h0333);
    cmd(sos_pkg::SOS_CMD_FIRE, 16'h0000);
    check(vset, 16'h0222);
    check({15'h0000, run_f[sos_pkg::OP_AWAIT]}, 16'h0000);
    check(iset, 16'h0020);
    check(run_f, 16'h0000);
    cmd(sos_pkg::SOS_CMD_IMMV, 16'h0444);
    cmd(sos_pkg::SOS_CMD_PENDV, 16'h0555);
    cmd(sos_pkg::SOS_CMD_FIRE, 16'h0000);
    check(vset, 16'h0444);
    cmd(sos_pkg::SOS_CMD_CONT, 16'h0001);
    cmd(sos_pkg::SOS_CMD_CANCEL, 16'h0000);
    check({15'h0000, run_f[sos_pkg::OP_AWAIT]}, 16'h0001);
    cmd(sos_pkg::SOS_CMD_CONT, 16'h0000);
    cmd(sos_pkg::SOS_CMD_RECALL, 16'h0000);
    check({15'h0000, run_f[sos_pkg::OP_AWAIT]}, 16'h0000);
    cmd(sos_pkg::SOS_CMD_ENABLE, 16'h0000);
    cmd(sos_pkg::SOS_CMD_RESET, 16'h0000);
    check({15'h0000, run_f[sos_pkg::OP_AWAIT]}, 16'h0000);
    cmd(sos_pkg::SOS_CMD_IMMI, 16'h0030);
    check(iset, 16'h0030);
    $display("Test trigger done");
    fault_force.therm = 1'b1;
    repeat (4) @(negedge mclk_in);
    check({15'h0000, flt_f[sos_pkg::FT_THERM]}, 16'h0001);
    cmd(sos_pkg::SOS_CMD_RUN, 16'h0000);
    check({15'h0000, cont}, 16'h0000);
    fault_force.therm = 1'b0;
    repeat (4) @(negedge mclk_in);
    cmd(sos_pkg::SOS_CMD_RUN, 16'h0000);
    check({15'h0000, cont}, 16'h0000);
    cmd(sos_pkg::SOS_CMD_CLEAR, 16'h0000);
    cmd(sos_pkg::SOS_CMD_RUN, 16'h0000);
    check({15'h0000, cont}, 16'h0001);
    cmd(sos_pkg::SOS_CMD_HALT, 16'h0000);
    $display("Test fault latch done");
    wr_mem(7'h63, 16'h0A99, 14'h0001);
    wr_mem(7'h00, 16'h0A00, sos_pkg::DWELL_ZERO);
    wr_mem(7'h01, 16'h0A01, 14'h0000);
    cmd(sos_pkg::SOS_CMD_START, 16'h0063);
    cmd(sos_pkg::SOS_CMD_SEQ, 16'h0001);
    check({15'h0000, seq_en}, 16'h0001);
    check({15'h0000, lamp}, 16'h0001);
    cmd(sos_pkg::SOS_CMD_RUN, 16'h0000);
    wait_for(0, 16'h0A99);
    check(iset, 16'h0001);
    wait_for(0, 16'h0A00);
    cmd(sos_pkg::SOS_CMD_RUN, 16'h0000);
    @(negedge mclk_in);
    check(vset, 16'h0000);
    wait_for(1, 16'h0000);
    $display("Test auto sequence done");
    report_and_stop();
  end
endmodule : test_supply_output_sequencer
bind sos_sequencer sos_chk i_chk (.mclk_in(mclk_in), .rst_in(rst_in), .req_in(req_in),
  .req_valid_in(req_valid_in), .fault_pin_in(fault_pin_in), .run_state_flags_out(run_state_flags_out),
  .fault_state_flags_out(fault_state_flags_out), .output_on_out(output_on_out),
  .contactor_out(contactor_out), .continuous_reenable_out(continuous_reenable_out));
